/* File: design/chan_mux_pkg.sv */
// Constants and types shared by the channel multiplexer control logic.
// Assumes a single system clock samples the upstream serial bus pins.
`default_nettype none

package chan_mux_pkg;

  // Control byte layout and its default value (channel 0 connected).
  localparam int          CTRL_W      = 8;
  localparam int          CHAN_N      = 8;
  localparam int          CHAN_SEL_W  = 3;
  localparam int          CTRL_EN_BIT = 3;
  localparam logic [7:0]  CTRL_RESET  = 8'h08;

  // Serial framing: data bits per byte and the direction bit position.
  localparam logic [3:0]  BYTE_BITS   = 4'h8;
  localparam int          RW_BIT      = 0;

  // Fixed upper part of the slave address; the value is arbitrary.
  localparam logic [3:0]  ADDR_PREFIX = 4'h7;

  // Bus protocol states of the slave.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR_DATA,
    ST_WR_ACK,
    ST_RD_DATA,
    ST_RD_ACK
  } bus_state_t;

endpackage

`default_nettype wire

/* File: design/chan_mux_ctrl.sv */
// Serial-bus slave that holds the channel select byte of an eight-way mux.
// Assumes clk is much faster than the bus clock; all pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Reset pin low restores control byte and clears bus state; channel 0 only.
// - Power-on reset holds the block, then defaults with channel 0 only.
// - Data changes while the clock is high are conditions, never data.
// - Data falling while clock high is a start; begins address reception.
// - Data rising while clock high is a stop; ends the transaction.
// - Each byte is eight bits plus one acknowledge bit clocked by master.
// - Any number of data bytes is accepted between start and stop.
// - When addressed as receiver, every received byte is acknowledged.
// - The acknowledger holds data low across the acknowledge clock high.
// - On a missing master acknowledge the slave releases data high.
// - Writes load the control byte; reads return its contents.
// - Bit 3 enables a channel, bits 2..0 pick it; default is channel 0.
// - A new channel selection takes effect only after the stop.
// - Of several written bytes only the last one is kept.
// - Address bit 0 high means read, low means write.
module chan_mux_ctrl
  import chan_mux_pkg::*;
#(
  parameter logic [3:0] ADDR_HI = chan_mux_pkg::ADDR_PREFIX
) (
  // Clock and power-on reset.
  input  wire logic                            clk,
  input  wire logic                            rst_b,
  // Reset pin and address select pins.
  input  wire logic                            reset_pin_b,
  input  wire logic [2:0]                      addr_sel,
  // Upstream serial bus; data is open drain.
  input  wire logic                            scl_i,
  input  wire logic                            sda_i,
  output logic                                 sda_o,
  output logic                                 sda_oe,
  // Channel connection state.
  output logic [chan_mux_pkg::CHAN_N-1:0]      chan_en,
  output logic [chan_mux_pkg::CTRL_W-1:0]      ctrl_value
);
  import chan_mux_pkg::*;

  typedef struct packed {
    logic                scl_s1;
    logic                scl_s2;
    logic                scl_p;
    logic                sda_s1;
    logic                sda_s2;
    logic                sda_p;
    logic                rstp_s1;
    logic                rstp_s2;
    logic [2:0]          asel_s1;
    logic [2:0]          asel_s2;
    bus_state_t          state;
    logic [3:0]          bit_cnt;
    logic [CTRL_W-1:0]   shift;
    logic                nack;
    logic                drive;
    logic [CTRL_W-1:0]   pend;
    logic                pend_v;
    logic [CTRL_W-1:0]   ctrl;
    logic [CHAN_N-1:0]   chan_en;
  } ctl_state_t;

  ctl_state_t q;
  ctl_state_t d;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       addr_ok;

  // Turns the control byte into a connection vector with at most one bit set.
  function automatic logic [CHAN_N-1:0] chan_decode(
    input logic [CTRL_W-1:0] c
  );
    logic [CHAN_N-1:0] r;
    r = '0;
    if (c[CTRL_EN_BIT]) begin
      r = CHAN_N'(1) << c[CHAN_SEL_W-1:0];
    end
    return r;
  endfunction

  // Edges and bus conditions come only from the second sync stage onward.
  assign scl_rise  = q.scl_s2 & ~q.scl_p;
  assign scl_fall  = ~q.scl_s2 & q.scl_p;
  assign start_det = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
  assign stop_det  = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
  assign addr_ok   = (q.shift[7:4] == ADDR_HI) &&
                     (q.shift[3:1] == q.asel_s2);

  // Next-state logic; pins first pass two flops before being looked at.
  always_comb begin
    d         = q;
    d.scl_s1  = scl_i;
    d.scl_s2  = q.scl_s1;
    d.scl_p   = q.scl_s2;
    d.sda_s1  = sda_i;
    d.sda_s2  = q.sda_s1;
    d.sda_p   = q.sda_s2;
    d.rstp_s1 = reset_pin_b;
    d.rstp_s2 = q.rstp_s1;
    d.asel_s1 = addr_sel;
    d.asel_s2 = q.asel_s1;
    if (!q.rstp_s2) begin
      // Pin reset frees the bus and restores channel 0.
      d.state   = ST_IDLE;
      d.bit_cnt = '0;
      d.drive   = 1'b0;
      d.nack    = 1'b0;
      d.pend_v  = 1'b0;
      d.ctrl    = CTRL_RESET;
      d.chan_en = chan_decode(CTRL_RESET);
    end else if (stop_det) begin
      // Switching only at stop keeps all downstream lines high at connect.
      d.state = ST_IDLE;
      d.drive = 1'b0;
      if (q.pend_v) begin
        d.ctrl    = q.pend;
        d.chan_en = chan_decode(q.pend);
      end
      d.pend_v = 1'b0;
    end else if (start_det) begin
      // A repeated start keeps any pending byte until the final stop.
      d.state   = ST_ADDR;
      d.bit_cnt = '0;
      d.drive   = 1'b0;
    end else begin
      // Data is sampled only on clock rise, so high-phase changes are
      // seen solely by the condition detectors above.
      unique case (q.state)
        ST_IDLE: begin
        end
        ST_ADDR, ST_WR_DATA: begin
          if (scl_rise) begin
            d.shift   = {q.shift[CTRL_W-2:0], q.sda_s2};
            d.bit_cnt = q.bit_cnt + 4'h1;
          end else if (scl_fall && q.bit_cnt == BYTE_BITS) begin
            d.bit_cnt = '0;
            if (q.state == ST_WR_DATA) begin
              d.pend   = q.shift;
              d.pend_v = 1'b1;
              d.drive  = 1'b1;
              d.state  = ST_WR_ACK;
            end else if (addr_ok) begin
              d.drive = 1'b1;
              d.state = ST_ADDR_ACK;
            end else begin
              d.state = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            d.bit_cnt = '0;
            if (q.shift[RW_BIT]) begin
              d.shift = q.ctrl;
              d.drive = ~q.ctrl[CTRL_W-1];
              d.state = ST_RD_DATA;
            end else begin
              d.drive = 1'b0;
              d.state = ST_WR_DATA;
            end
          end
        end
        ST_WR_ACK: begin
          // Acknowledge held through the whole ninth clock.
          if (scl_fall) begin
            d.drive = 1'b0;
            d.state = ST_WR_DATA;
          end
        end
        ST_RD_DATA: begin
          if (scl_rise) begin
            d.bit_cnt = q.bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (q.bit_cnt == BYTE_BITS) begin
              d.drive = 1'b0;
              d.state = ST_RD_ACK;
            end else begin
              d.shift = {q.shift[CTRL_W-2:0], 1'b0};
              d.drive = ~q.shift[CTRL_W-2];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            d.nack = q.sda_s2;
          end else if (scl_fall) begin
            d.bit_cnt = '0;
            if (q.nack) begin
              d.drive = 1'b0;
              d.state = ST_IDLE;
            end else begin
              d.shift = q.ctrl;
              d.drive = ~q.ctrl[CTRL_W-1];
              d.state = ST_RD_DATA;
            end
          end
        end
      endcase
    end
  end

  // Power-on reset gives defaults; scl, sda and reset-pin sync flops idle high like the bus.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q         <= '0;
      q.scl_s1  <= 1'b1;
      q.scl_s2  <= 1'b1;
      q.scl_p   <= 1'b1;
      q.sda_s1  <= 1'b1;
      q.sda_s2  <= 1'b1;
      q.sda_p   <= 1'b1;
      q.rstp_s1 <= 1'b1;
      q.rstp_s2 <= 1'b1;
      q.ctrl    <= CTRL_RESET;
      q.chan_en <= 8'h01;
    end else begin
      q <= d;
    end
  end

  // The slave only ever pulls low; release lets the pull-up win.
  assign sda_o      = 1'b0;
  assign sda_oe     = q.drive;
  assign chan_en    = q.chan_en;
  assign ctrl_value = q.ctrl;

  property p_pin_reset;
    @(posedge clk) disable iff (!rst_b)
    !q.rstp_s2 |=> q.state == ST_IDLE && q.ctrl == CTRL_RESET && !q.drive;
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("pin reset did not restore defaults");

  property p_start;
    @(posedge clk) disable iff (!rst_b)
    (start_det && q.rstp_s2 && !stop_det)
      |=> q.state == ST_ADDR && q.bit_cnt == 4'h0;
  endproperty
  a_start: assert property (p_start)
    else $error("start condition not taken");

  property p_stop;
    @(posedge clk) disable iff (!rst_b)
    stop_det |=> q.state == ST_IDLE && !q.drive;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop condition did not end transaction");

  property p_write_ack;
    @(posedge clk) disable iff (!rst_b)
    (q.state == ST_WR_DATA && scl_fall && q.bit_cnt == BYTE_BITS &&
     q.rstp_s2 && !start_det && !stop_det)
      |=> q.state == ST_WR_ACK && sda_oe && q.pend == $past(q.shift);
  endproperty
  a_write_ack: assert property (p_write_ack)
    else $error("received byte not acknowledged");

  property p_ack_low;
    @(posedge clk) disable iff (!rst_b)
    ((q.state == ST_WR_ACK || q.state == ST_ADDR_ACK) && q.scl_s2)
      |-> sda_oe && !sda_o;
  endproperty
  a_ack_low: assert property (p_ack_low)
    else $error("acknowledge released during clock high");

  property p_nack_release;
    @(posedge clk) disable iff (!rst_b)
    (q.state == ST_RD_ACK && q.nack && scl_fall && q.rstp_s2 &&
     !start_det && !stop_det)
      |=> q.state == ST_IDLE ##1 !sda_oe;
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("data line not released after missing acknowledge");

  property p_read_load;
    @(posedge clk) disable iff (!rst_b)
    (q.state == ST_ADDR_ACK && scl_fall && q.shift[RW_BIT] &&
     q.rstp_s2 && !start_det && !stop_det)
      |=> q.state == ST_RD_DATA && q.shift == q.ctrl &&
          sda_oe == !q.ctrl[CTRL_W-1];
  endproperty
  a_read_load: assert property (p_read_load)
    else $error("read did not return the control byte");

  property p_decode;
    @(posedge clk) disable iff (!rst_b)
    q.chan_en == chan_decode(q.ctrl);
  endproperty
  a_decode: assert property (p_decode)
    else $error("channel enables disagree with control byte");

  property p_hold_until_stop;
    @(posedge clk) disable iff (!rst_b)
    (!stop_det && q.rstp_s2) |=> $stable(q.ctrl);
  endproperty
  a_hold_until_stop: assert property (p_hold_until_stop)
    else $error("control byte changed without a stop");

  property p_commit_last;
    @(posedge clk) disable iff (!rst_b)
    (stop_det && q.pend_v && q.rstp_s2) |=> q.ctrl == $past(q.pend);
  endproperty
  a_commit_last: assert property (p_commit_last)
    else $error("last written byte not committed at stop");

  property p_addr_reject;
    @(posedge clk) disable iff (!rst_b)
    (q.state == ST_ADDR && scl_fall && q.bit_cnt == BYTE_BITS &&
     !addr_ok && q.rstp_s2 && !start_det && !stop_det)
      |=> q.state == ST_IDLE ##1 !sda_oe [*2];
  endproperty
  a_addr_reject: assert property (p_addr_reject)
    else $error("foreign address was acknowledged");

endmodule

`default_nettype wire

/* File: tb/bus_master_model.sv */
// Behavioural upstream bus master that makes the bus clock and data.
// Assumes the data line is resolved outside with a pull-up; 1 releases it.
`timescale 1ns/100ps
`default_nettype none

module bus_master_model (
  // Bus clock made by this master.
  output logic      scl,
  // Open-drain data: drive request and resolved line level.
  output logic      sda_drv,
  input  wire logic sda_line
);
  // Quarter of the 800 ns bit period, so every step lands on a clk low.
  localparam int Q = 200;

  // Both lines idle high, so the clock stands still between frames.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // One bit: data moves only while the clock is low, sampled mid-high.
  task automatic bit_cycle(input logic b, output logic seen);
    sda_drv = b;
    #Q scl = 1'b1;
    #Q seen = sda_line;
    #Q scl = 1'b0;
    #Q;
  endtask

  // Start from idle or repeated start: data falls with the clock high.
  task automatic start();
    sda_drv = 1'b1;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask

  // Stop leaves both lines high, which is the idle bus.
  task automatic stop();
    sda_drv = 1'b0;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b1;
    #(2*Q);
  endtask

  // Eight bits MSB first, then a released ninth bit for the slave ack.
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(b[i], s);
    end
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask

  // Reads eight bits; acks low unless this is the final byte.
  task automatic read_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, d[i]);
    end
    bit_cycle(last, s);
  endtask
endmodule

`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the channel mux control slave.
// Assumes the master model drives the bus; data has a pull-up here.
`timescale 1ns/100ps
`default_nettype none

module tb;
  import chan_mux_pkg::*;

  // Ordinary case: written byte beside the connection it should give.
  typedef struct packed {
    logic [7:0] val;
    logic [7:0] chan;
  } row_t;

  logic       clk;
  logic       rst_b;
  logic       reset_pin_b;
  logic [2:0] addr_sel;
  wire  logic scl;
  wire  logic sda_drv;
  wire  logic sda;
  logic       sda_o;
  logic       sda_oe;
  logic [7:0] chan_en;
  logic [7:0] ctrl_value;
  logic       ak;
  logic [7:0] rd;
  logic [7:0] prev;
  int         err_total;
  int         comparisons;
  row_t       rows [10];

  // Open-drain wire: low if either party pulls, else the pull-up wins.
  assign sda = (sda_oe ? sda_o : 1'b1) & sda_drv;

  chan_mux_ctrl dut_u (
    .clk(clk), .rst_b(rst_b), .reset_pin_b(reset_pin_b),
    .addr_sel(addr_sel), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .chan_en(chan_en), .ctrl_value(ctrl_value)
  );

  bus_master_model master_u (.scl(scl), .sda_drv(sda_drv), .sda_line(sda));

  // Free-running 10 MHz system clock.
  initial clk = 1'b0;
  always #50 clk = ~clk;

  // Compare one value and count it; an unknown never matches.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Start, then the address byte with its direction bit (1 reads).
  task automatic address(input logic [2:0] sel, input logic rdir,
                         output logic a);
    master_u.start();
    master_u.write_byte({ADDR_PREFIX, sel, rdir}, a);
  endtask

  // A stop commits three clk edges later; two more cycles give margin.
  task automatic stop_settle();
    master_u.stop();
    repeat (2) @(negedge clk);
  endtask

  // One-byte read of the active control byte, ended by a missing ack.
  task automatic expect_read(input logic [7:0] exp);
    address(addr_sel, 1'b1, ak);
    check({7'h00, ak}, 8'h01);
    master_u.read_byte(1'b1, rd);
    check(rd, exp);
    stop_settle();
  endtask

  // Hang guard: the run needs just under a tenth of this.
  initial begin
    #5000000;
    err_total++;
    $display("wrong value at %0t ns: run did not finish", $time);
    summarize();
  end

  initial begin
    rows = '{16'h0801, 16'h0902, 16'h0A04, 16'h0B08, 16'h0C10,
             16'h0D20, 16'h0E40, 16'h0F80, 16'h0700, 16'hA902};
    rst_b = 1'b0;
    reset_pin_b = 1'b1;
    addr_sel = 3'h5;
    err_total = 0;
    comparisons = 0;
    prev = CTRL_RESET;
    repeat (3) @(negedge clk);
    check(ctrl_value, CTRL_RESET);
    check(chan_en, 8'h01);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    check({7'h00, sda_oe}, 8'h00);
    $display("test power-on reset done");

    // Every channel code, one disabled code and stored upper bits.
    foreach (rows[i]) begin
      address(addr_sel, 1'b0, ak);
      check({7'h00, ak}, 8'h01);
      master_u.write_byte(rows[i].val, ak);
      check({7'h00, ak}, 8'h01);
      check(ctrl_value, prev);
      stop_settle();
      check(ctrl_value, rows[i].val);
      check(chan_en, rows[i].chan);
      expect_read(rows[i].val);
      prev = rows[i].val;
    end
    $display("test channel table done");

    // A foreign address gets no ack and its data changes nothing.
    address(~addr_sel, 1'b0, ak);
    check({7'h00, ak}, 8'h00);
    master_u.write_byte(8'h0C, ak);
    stop_settle();
    check(ctrl_value, prev);
    $display("test foreign address done");

    // New select pins, three bytes, repeated start before the stop.
    addr_sel = 3'h2;
    repeat (3) @(negedge clk);
    address(addr_sel, 1'b0, ak);
    for (int k = 0; k < 3; k++) begin
      master_u.write_byte(8'h0C + 8'(k), ak);
      check({7'h00, ak}, 8'h01);
    end
    master_u.start();
    stop_settle();
    check(ctrl_value, 8'h0E);
    check(chan_en, 8'h40);
    $display("test multi-byte write done");

    // Two-byte read: ack on the first, none on the last.
    address(addr_sel, 1'b1, ak);
    master_u.read_byte(1'b0, rd);
    check(rd, 8'h0E);
    master_u.read_byte(1'b1, rd);
    check(rd, 8'h0E);
    // A slave that missed the nack would pull low 250 ns after the fall.
    repeat (2) @(negedge clk);
    check({7'h00, sda_oe}, 8'h00);
    stop_settle();
    $display("test multi-byte read done");

    // Reset pin in mid-write drops the pending byte.
    address(addr_sel, 1'b0, ak);
    master_u.write_byte(8'h0B, ak);
    reset_pin_b = 1'b0;
    repeat (4) @(negedge clk);
    check(ctrl_value, CTRL_RESET);
    check(chan_en, 8'h01);
    reset_pin_b = 1'b1;
    repeat (3) @(negedge clk);
    stop_settle();
    check(ctrl_value, CTRL_RESET);
    expect_read(CTRL_RESET);
    $display("test reset pin done");
    summarize();
  end
endmodule

`default_nettype wire
